// ---- src/e3_rx_parity_check.sv ----
// Receive frame parity check with far-end error signalling, interrupt and counter
// Notes on behaviour
// RULE_01 - When enabled, compute frame parity and compare with next frame's monitor byte.
// RULE_02 - Matching parity makes the transmitter send remote-alarm bit zero.
// RULE_03 - Mismatching parity makes the transmitter send remote-alarm bit one.
// RULE_04 - Mismatch sets status bit 2 at 0x15; reading clears it.
// RULE_05 - Mismatch increments 16-bit counter, high byte 0x54, low byte 0x55.
// RULE_06 - Both counter bytes reset to zero when read.
// RULE_07 - Config bit 7 at 0x30 enables inserting parity into outbound frames.
// RULE_08 - Enable bit 2 at 0x13 lets parity errors raise the interrupt.
// RULE_09 - Remote-failure bit 3 of status register also clears on read.
// RULE_10 - Parity is four-way interleaved even parity over all frame bits.
// RULE_11 - Event arriving with a read-clear is kept, not lost.
`timescale 1ns/1ps
module e3_rx_parity_check (
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [7:0]       RDATA,
    input  wire logic        RX_VALID,
    input  wire logic        RX_SOF,
    input  wire logic        RX_DATA,
    input  wire logic        RX_EM_STROBE,
    input  wire logic [3:0]  RX_EM_NIBBLE,
    input  wire logic        RX_CHECK_ENABLE,
    input  wire logic        REMOTE_FAIL_EVENT,
    output logic             FAR_END_ERROR_SIGNAL,
    output logic             TX_PARITY_INSERT_ENABLE,
    output logic [3:0]       TX_PARITY,
    output logic             PARITY_ERROR_PULSE,
    output logic             IRQ
);
    typedef struct packed {
        logic [7:0]  int_enable;
        logic [7:0]  int_status;
        logic [7:0]  tx_config;
        logic [15:0] err_count;
        logic [7:0]  rdata;
        logic        far_end;
        logic [3:0]  tx_parity;
        logic        err_pulse;
    } top_state_t;

    top_state_t                     st;
    top_state_t                     next_st;
    parity_check_pkg::line_bit_t    line_in;
    parity_check_pkg::frame_par_t   frame_res;
    logic [3:0]                     em_value;
    logic                           em_valid;
    logic                           mismatch;
    logic                           compare;

    assign line_in.valid = RX_VALID;
    assign line_in.sof   = RX_SOF;
    assign line_in.data  = RX_DATA;

    frame_parity_acc #(
        .PAR_W (parity_check_pkg::PAR_W)
    ) u_acc (
        .clk    (CLK_SYS),
        .nrst   (NRST),
        .in_bit (line_in),
        .result (frame_res)
    );

    // Monitor byte of frame N+1 checks parity of frame N
    error_monitor_capture u_em (
        .clk        (CLK_SYS),
        .nrst       (NRST),
        .em_strobe  (RX_EM_STROBE),
        .em_nibble  (RX_EM_NIBBLE),
        .frame_done (frame_res.done),
        .em_value   (em_value),
        .em_valid   (em_valid)
    );

    // Saturating add keeps a stuck-high count readable
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == parity_check_pkg::COUNT_MAX) ? v : v + 16'h0001;
    endfunction : sat_inc

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        addr_hit = (a == ofs);
    endfunction : addr_hit

    // The held parity of the previous frame meets the monitor nibble at its boundary
    logic [3:0] prev_parity;
    logic       prev_valid;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            prev_parity <= 4'h0;
            prev_valid  <= 1'b0;
        end else if (frame_res.done) begin
            prev_parity <= frame_res.parity;
            prev_valid  <= 1'b1;
        end
    end

    assign compare  = RX_CHECK_ENABLE && frame_res.done && prev_valid && em_valid; // RULE_01
    assign mismatch = compare && (prev_parity != em_value);                      // RULE_01

    always_comb begin
        logic rd_status;
        logic rd_hi;
        logic rd_lo;
        logic fail_set;
        rd_status = RD && addr_hit(ADDR, parity_check_pkg::OFS_RX_INT_STATUS_TWO);
        rd_hi     = RD && addr_hit(ADDR, parity_check_pkg::OFS_PAR_COUNT_HIGH);
        rd_lo     = RD && addr_hit(ADDR, parity_check_pkg::OFS_PAR_COUNT_LOW);
        fail_set  = REMOTE_FAIL_EVENT;
        next_st           = st;
        next_st.err_pulse = mismatch;

        // Register writes
        if (WR) begin
            if (addr_hit(ADDR, parity_check_pkg::OFS_RX_INT_ENABLE_TWO)) begin
                next_st.int_enable = WDATA & parity_check_pkg::INT_ENABLE_MASK;
            end
            if (addr_hit(ADDR, parity_check_pkg::OFS_TX_LINE_CONFIG)) begin
                next_st.tx_config = WDATA;
            end
            if (addr_hit(ADDR, parity_check_pkg::OFS_INT_CLEAR)) begin
                next_st.int_status = st.int_status & ~(WDATA & parity_check_pkg::INT_STATUS_MASK);
            end
        end

        // Read data, one cycle after the strobe
        next_st.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                parity_check_pkg::OFS_RX_INT_ENABLE_TWO: next_st.rdata = st.int_enable;
                parity_check_pkg::OFS_RX_INT_STATUS_TWO: next_st.rdata = st.int_status;
                parity_check_pkg::OFS_TX_LINE_CONFIG:    next_st.rdata = st.tx_config;
                parity_check_pkg::OFS_PAR_COUNT_HIGH:    next_st.rdata = st.err_count[15:8];
                parity_check_pkg::OFS_PAR_COUNT_LOW:     next_st.rdata = st.err_count[7:0];
                default:                                 next_st.rdata = 8'h00;
            endcase
        end

        // Read clears first, new events after so they win
        if (rd_status) begin
            next_st.int_status[parity_check_pkg::BIT_PARITY_ERR]  = 1'b0; // RULE_04
            next_st.int_status[parity_check_pkg::BIT_REMOTE_FAIL] = 1'b0; // RULE_09
        end
        if (rd_hi) begin
            next_st.err_count[15:8] = 8'h00; // RULE_06
        end
        if (rd_lo) begin
            next_st.err_count[7:0] = 8'h00; // RULE_06
        end
        if (fail_set) begin
            next_st.int_status[parity_check_pkg::BIT_REMOTE_FAIL] = 1'b1; // RULE_11
        end
        if (mismatch) begin
            next_st.int_status[parity_check_pkg::BIT_PARITY_ERR] = 1'b1; // RULE_04 RULE_11
            // Count on top of a byte just cleared, so the unread byte survives
            next_st.err_count = sat_inc(next_st.err_count); // RULE_05 RULE_11
        end

        // Result of each comparison goes out on the remote-alarm bit
        if (compare) begin
            next_st.far_end = mismatch; // RULE_02 RULE_03
        end
        if (frame_res.done) begin
            next_st.tx_parity = frame_res.parity; // RULE_07
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            st            <= '0;
            st.int_enable <= parity_check_pkg::INT_ENABLE_RESET;
            st.tx_config  <= parity_check_pkg::TX_CONFIG_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign RDATA                   = st.rdata;
    assign FAR_END_ERROR_SIGNAL    = st.far_end;
    assign TX_PARITY_INSERT_ENABLE = st.tx_config[parity_check_pkg::BIT_TX_PARITY_EN]; // RULE_07
    assign TX_PARITY               = st.tx_config[parity_check_pkg::BIT_TX_PARITY_EN]
                                     ? st.tx_parity : 4'h0;                       // RULE_07
    assign PARITY_ERROR_PULSE      = st.err_pulse;
    assign IRQ = |(st.int_status & st.int_enable & parity_check_pkg::INT_STATUS_MASK); // RULE_08

    property p_alarm_one;
        @(posedge CLK_SYS) disable iff (!NRST)
        mismatch |=> FAR_END_ERROR_SIGNAL;
    endproperty
    a_alarm_one: assert property (p_alarm_one) else $error("alarm bit not set"); // RULE_03

    property p_alarm_zero;
        @(posedge CLK_SYS) disable iff (!NRST)
        (compare && !mismatch) |=> !FAR_END_ERROR_SIGNAL;
    endproperty
    a_alarm_zero: assert property (p_alarm_zero) else $error("alarm bit not cleared"); // RULE_02

    property p_status_set;
        @(posedge CLK_SYS) disable iff (!NRST)
        mismatch |=> st.int_status[2];
    endproperty
    a_status_set: assert property (p_status_set) else $error("status flag lost"); // RULE_04

    property p_status_rc;
        @(posedge CLK_SYS) disable iff (!NRST)
        (RD && ADDR == 8'h15 && !mismatch) |=> !st.int_status[2];
    endproperty
    a_status_rc: assert property (p_status_rc) else $error("status not cleared"); // RULE_04

    property p_fail_rc;
        @(posedge CLK_SYS) disable iff (!NRST)
        (RD && ADDR == 8'h15 && !REMOTE_FAIL_EVENT) |=> !st.int_status[3];
    endproperty
    a_fail_rc: assert property (p_fail_rc) else $error("fail bit not cleared"); // RULE_09

    property p_count_inc;
        @(posedge CLK_SYS) disable iff (!NRST)
        (mismatch && !RD && st.err_count != 16'hffff)
            |=> st.err_count == $past(st.err_count) + 16'h0001;
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("counter not incremented"); // RULE_05

    property p_count_rc;
        @(posedge CLK_SYS) disable iff (!NRST)
        (RD && ADDR == 8'h55 && !mismatch) |=> st.err_count[7:0] == 8'h00;
    endproperty
    a_count_rc: assert property (p_count_rc) else $error("low byte not cleared"); // RULE_06

    property p_irq;
        @(posedge CLK_SYS) disable iff (!NRST)
        (st.int_enable[2] && st.int_status[2]) |-> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing"); // RULE_08

    property p_keep_event;
        @(posedge CLK_SYS) disable iff (!NRST)
        (mismatch && RD && ADDR == 8'h15) |=> st.int_status[2] ##1 1'b1;
    endproperty
    a_keep_event: assert property (p_keep_event) else $error("event lost to read"); // RULE_11

    // Register side: read-clear, write effects and hold between events
    property p_count_hi_rc;
        @(posedge CLK_SYS) disable iff (!NRST)
        (RD && ADDR == parity_check_pkg::OFS_PAR_COUNT_HIGH && !mismatch)
            |=> st.err_count[15:8] == 8'h00;
    endproperty
    a_count_hi_rc: assert property (p_count_hi_rc) else $error("high byte kept"); // RULE_06

    property p_fail_set;
        @(posedge CLK_SYS) disable iff (!NRST)
        REMOTE_FAIL_EVENT
            |=> st.int_status[parity_check_pkg::BIT_REMOTE_FAIL];
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("fail bit lost"); // RULE_09

    property p_pulse_on;
        @(posedge CLK_SYS) disable iff (!NRST)
        mismatch
            |=> PARITY_ERROR_PULSE;
    endproperty
    a_pulse_on: assert property (p_pulse_on) else $error("error pulse missing"); // RULE_05

    property p_pulse_off;
        @(posedge CLK_SYS) disable iff (!NRST)
        !mismatch
            |=> !PARITY_ERROR_PULSE;
    endproperty
    a_pulse_off: assert property (p_pulse_off) else $error("stray error pulse"); // RULE_05

    property p_far_hold;
        @(posedge CLK_SYS) disable iff (!NRST)
        !compare
            |=> $stable(FAR_END_ERROR_SIGNAL);
    endproperty
    a_far_hold: assert property (p_far_hold) else $error("alarm bit moved"); // RULE_02 RULE_03

    property p_tx_parity;
        @(posedge CLK_SYS) disable iff (!NRST)
        frame_res.done
            |=> st.tx_parity == $past(frame_res.parity);
    endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("tx parity stale"); // RULE_07

    property p_insert_en;
        @(posedge CLK_SYS) disable iff (!NRST)
        (WR && ADDR == parity_check_pkg::OFS_TX_LINE_CONFIG)
            |=> TX_PARITY_INSERT_ENABLE == $past(WDATA[parity_check_pkg::BIT_TX_PARITY_EN]);
    endproperty
    a_insert_en: assert property (p_insert_en) else $error("insert enable wrong"); // RULE_07

    property p_enable_write;
        @(posedge CLK_SYS) disable iff (!NRST)
        (WR && ADDR == parity_check_pkg::OFS_RX_INT_ENABLE_TWO)
            |=> st.int_enable == ($past(WDATA) & parity_check_pkg::INT_ENABLE_MASK);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not written"); // RULE_08

    property p_irq_off;
        @(posedge CLK_SYS) disable iff (!NRST)
        (!st.int_enable[parity_check_pkg::BIT_PARITY_ERR]
            && !st.int_enable[parity_check_pkg::BIT_REMOTE_FAIL]) |-> !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while masked"); // RULE_08

    property p_status_ro;
        @(posedge CLK_SYS) disable iff (!NRST)
        (WR && ADDR == parity_check_pkg::OFS_RX_INT_STATUS_TWO
            && !mismatch && !REMOTE_FAIL_EVENT) |=> $stable(st.int_status);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status written"); // RULE_04

    property p_count_hold;
        @(posedge CLK_SYS) disable iff (!NRST)
        (!mismatch && !RD)
            |=> $stable(st.err_count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved"); // RULE_05

    property p_status_hold;
        @(posedge CLK_SYS) disable iff (!NRST)
        (!mismatch && !REMOTE_FAIL_EVENT && !RD && !WR)
            |=> $stable(st.int_status);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status moved"); // RULE_04

    property p_rdata_status;
        @(posedge CLK_SYS) disable iff (!NRST)
        (RD && ADDR == parity_check_pkg::OFS_RX_INT_STATUS_TWO)
            |=> RDATA == $past(st.int_status);
    endproperty
    a_rdata_status: assert property (p_rdata_status) else $error("status read wrong"); // RULE_04

    property p_rdata_low;
        @(posedge CLK_SYS) disable iff (!NRST)
        (RD && ADDR == parity_check_pkg::OFS_PAR_COUNT_LOW)
            |=> RDATA == $past(st.err_count[7:0]);
    endproperty
    a_rdata_low: assert property (p_rdata_low) else $error("low byte read wrong"); // RULE_05

endmodule : e3_rx_parity_check

// ---- src/error_monitor_capture.sv ----
// Captures the error-monitor nibble carried in each frame
`timescale 1ns/1ps
module error_monitor_capture (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        em_strobe,
    input  wire logic [3:0]  em_nibble,
    input  wire logic        frame_done,
    output logic [3:0]       em_value,
    output logic             em_valid
);
    typedef struct packed {
        logic [3:0] value;
        logic       valid;
    } em_state_t;

    em_state_t st;
    em_state_t next_st;

    always_comb begin
        next_st = st;
        if (em_strobe) begin
            next_st.value = em_nibble;
            next_st.valid = 1'b1;
        end else if (frame_done) begin
            // Consumed by the comparison at the frame boundary
            next_st.valid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign em_value = st.value;
    assign em_valid = st.valid;

endmodule : error_monitor_capture

// ---- src/frame_parity_acc.sv ----
// Interleaved even parity accumulator over one received frame
`timescale 1ns/1ps
module frame_parity_acc #(
    parameter int PAR_W = parity_check_pkg::PAR_W
) (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire parity_check_pkg::line_bit_t   in_bit,
    output parity_check_pkg::frame_par_t       result
);
    typedef struct packed {
        logic [PAR_W-1:0] acc;
        logic [1:0]       pos;
        logic             started;
        parity_check_pkg::frame_par_t out;
    } acc_state_t;

    acc_state_t st;
    acc_state_t next_st;

    always_comb begin
        next_st          = st;
        next_st.out.done = 1'b0;
        if (in_bit.valid) begin
            if (in_bit.sof) begin
                // Close the previous frame, start the next with this bit
                next_st.out.done   = st.started;
                next_st.out.parity = st.acc;
                next_st.acc        = '0;
                next_st.acc[0]     = in_bit.data;
                next_st.pos        = 2'h1;
                next_st.started    = 1'b1;
            end else begin
                next_st.acc[st.pos] = st.acc[st.pos] ^ in_bit.data; // RULE_10
                next_st.pos         = st.pos + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign result = st.out;

endmodule : frame_parity_acc

// ---- src/parity_check_pkg.sv ----
// Package: register map, field positions and types for the frame parity checker
package parity_check_pkg;

    localparam int        ADDR_W              = 8;
    localparam int        DATA_W              = 8;
    localparam int        PAR_W               = 4;
    localparam int        CNT_W               = 16;

    // Register offsets
    localparam logic [7:0] OFS_RX_INT_ENABLE_TWO  = 8'h13;
    localparam logic [7:0] OFS_RX_INT_STATUS_TWO  = 8'h15;
    localparam logic [7:0] OFS_TX_LINE_CONFIG     = 8'h30;
    localparam logic [7:0] OFS_PAR_COUNT_HIGH     = 8'h54;
    localparam logic [7:0] OFS_PAR_COUNT_LOW      = 8'h55;
    localparam logic [7:0] OFS_INT_CLEAR          = 8'h16;

    // Field positions
    localparam int        BIT_PARITY_ERR      = 2;
    localparam int        BIT_REMOTE_FAIL     = 3;
    localparam int        BIT_TX_PARITY_EN    = 7;

    // Writable masks and reset values
    localparam logic [7:0] INT_ENABLE_MASK    = 8'h8e;
    localparam logic [7:0] INT_STATUS_MASK    = 8'h0c;
    localparam logic [7:0] INT_ENABLE_RESET   = 8'h00;
    localparam logic [7:0] TX_CONFIG_RESET    = 8'h00;
    localparam logic [15:0] COUNT_MAX         = 16'hffff;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       data;
    } line_bit_t;

    typedef struct packed {
        logic       done;
        logic [3:0] parity;
        logic [3:0] em_nibble;
        logic       em_valid;
    } frame_par_t;

endpackage : parity_check_pkg

// ---- test/e3_remote_terminal.sv ----
// Remote terminal model: sends frames and monitor nibbles toward the checker
`timescale 1ns/1ps
module e3_remote_terminal (
    input  wire logic  clk,
    output logic       valid,
    output logic       sof,
    output logic       data,
    output logic       em_strobe,
    output logic [3:0] em_nibble
);
    logic       busy     = 1'b0;
    logic       drv      = 1'b0;
    logic [3:0] nib      = 4'h0;
    logic       idle_pat = 1'b0;

    initial begin
        valid     = 1'b0;
        sof       = 1'b0;
        em_strobe = 1'b0;
    end

    // A released line toggles, so a stale bit never passes for a real one
    always @(posedge clk) begin
        idle_pat <= ~idle_pat;
    end
    assign data      = busy ? drv : idle_pat;
    assign em_nibble = em_strobe ? nib : {4{idle_pat}};

    task automatic send_frame(input logic [31:0] bits, input int len, input logic em_on,
                              input logic [3:0] value);
        for (int k = 0; k < len; k++) begin
            @(posedge clk);
            busy      <= 1'b1;
            valid     <= 1'b1;
            sof       <= (k == 0);
            drv       <= bits[k];
            // Strobe well before the closing start-of-frame
            em_strobe <= em_on && (k == 2);
            nib       <= value;
        end
        @(posedge clk);
        busy      <= 1'b0;
        valid     <= 1'b0;
        sof       <= 1'b0;
        em_strobe <= 1'b0;
    endtask : send_frame
endmodule : e3_remote_terminal

// ---- test/testbench.sv ----
// Self-checking bench for the receive frame parity checker
`timescale 1ns/1ps
module testbench;
    logic       clk_sys  = 1'b0;
    logic       nrst     = 1'b0;
    logic [7:0] addr     = 8'h00;
    logic [7:0] wdata    = 8'h00;
    logic       wr       = 1'b0;
    logic       rd       = 1'b0;
    logic       check_en = 1'b0;
    logic       rem_fail = 1'b0;
    logic [7:0] rdata;
    logic       rx_valid, rx_sof, rx_data, em_strobe, far_end, tx_ins_en, par_pulse, irq;
    logic [3:0] em_nibble, tx_par;
    int         error_cnt   = 0;
    int         checks_done = 0;
    int         pulses      = 0;
    int         cnt = 0, n_err = 0, stat = 0, ena = 0, frame_n = 0;
    logic       exp_far = 1'b0;
    logic       tx_on   = 1'b0;
    logic [3:0] par_q[$];
    logic [3:0] nib_q[$];
    logic       em_q[$];

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    e3_remote_terminal u_remote (.clk(clk_sys), .valid(rx_valid), .sof(rx_sof),
        .data(rx_data), .em_strobe(em_strobe), .em_nibble(em_nibble));

    e3_rx_parity_check dut_u (.CLK_SYS(clk_sys), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .RX_VALID(rx_valid), .RX_SOF(rx_sof),
        .RX_DATA(rx_data), .RX_EM_STROBE(em_strobe), .RX_EM_NIBBLE(em_nibble),
        .RX_CHECK_ENABLE(check_en), .REMOTE_FAIL_EVENT(rem_fail),
        .FAR_END_ERROR_SIGNAL(far_end), .TX_PARITY_INSERT_ENABLE(tx_ins_en),
        .TX_PARITY(tx_par), .PARITY_ERROR_PULSE(par_pulse), .IRQ(irq));

    always @(posedge clk_sys) begin
        if (par_pulse === 1'b1) pulses++;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask : reg_wr

    // Read data is valid only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    task automatic read_counts();
        rd_chk(8'h15, stat[7:0]);
        stat = 0;
        rd_chk(8'h55, cnt[7:0]);
        cnt = cnt & 16'hff00;
        rd_chk(8'h54, cnt[15:8]);
        cnt = cnt & 16'h00ff;
        rd_chk(8'h55, 8'h00);
    endtask : read_counts

    task automatic pulse_fail();
        @(posedge clk_sys);
        rem_fail <= 1'b1;
        @(posedge clk_sys);
        rem_fail <= 1'b0;
        stat = stat | 8;
        #1;
        chk(irq, (stat & ena) != 0);
    endtask : pulse_fail

    // One frame; its start closes the previous frame and judges the one before
    task automatic frame(input logic err, input logic em_on);
        logic [31:0] bits;
        logic [3:0]  p;
        logic [3:0]  nib;
        int          len;
        bits = $urandom;
        len  = 8 + $urandom % 20;
        p    = 4'h0;
        for (int k = 0; k < len; k++) p[k % 4] ^= bits[k];
        nib = (frame_n > 0) ? par_q[frame_n - 1] : 4'h0;
        if (err) nib = nib ^ (4'h1 << ($urandom % 4));
        u_remote.send_frame(bits, len, em_on, nib);
        if (frame_n >= 2 && em_q[frame_n - 1] && check_en) begin
            exp_far = (par_q[frame_n - 2] !== nib_q[frame_n - 1]);
            if (exp_far) begin
                n_err++;
                cnt++;
                stat = stat | 4;
            end
        end
        par_q.push_back(p);
        nib_q.push_back(nib);
        em_q.push_back(em_on);
        frame_n++;
        #1;
        chk(far_end, exp_far);
        chk(tx_par, (tx_on && frame_n > 1) ? par_q[frame_n - 2] : 4'h0);
        chk(irq, (stat & ena) != 0);
        chk(tx_ins_en, tx_on);
    endtask : frame

    initial begin
        void'($urandom(22279));
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        rd_chk(8'h13, 8'h00);
        rd_chk(8'h30, 8'h00);
        read_counts();
        reg_wr(8'h77, 8'h5a);
        rd_chk(8'h77, 8'h00);
        reg_wr(8'h13, 8'hff);
        ena = 8'h8e;
        rd_chk(8'h13, parity_check_pkg::INT_ENABLE_MASK);
        reg_wr(8'h30, 8'h80);
        tx_on = 1'b1;
        reg_wr(8'h15, 8'hff);
        rd_chk(8'h30, 8'h80);
        rd_chk(8'h15, 8'h00);
        for (int i = 0; i < 30; i++) begin
            @(posedge clk_sys);
            // Checking switched off for a stretch of frames
            check_en <= !(i >= 18 && i < 22);
            frame($urandom % 2, (i % 7) != 3);
            if (i == 10) pulse_fail();
            if (i % 6 == 5) read_counts();
        end
        pulse_fail();
        reg_wr(8'h13, 8'h00);
        ena = 0;
        #1;
        chk(irq, 1'b0);
        reg_wr(8'h16, 8'h0c);
        stat = 0;
        rd_chk(8'h15, 8'h00);
        reg_wr(8'h30, 8'h00);
        tx_on = 1'b0;
        frame(1'b1, 1'b1);
        fork
            frame(1'b0, 1'b1);
            begin
                // Status read lands in the cycle of a certain mismatch
                repeat (2) @(posedge clk_sys);
                addr <= 8'h15;
                rd   <= 1'b1;
                @(posedge clk_sys);
                rd   <= 1'b0;
                #1;
                chk(rdata, stat[7:0]);
                stat = 0;
            end
        join
        read_counts();
        chk(pulses, n_err);
        end_sim();
    end

    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule : testbench
